// *** design/brg_addr_gen.sv ***
// Bit-reverse pointer address generator with register-space read sequencer
//
// Behaviour
// - Access uses the pointer before update; pointer changes only afterwards.
// - Compat mode off, plus form: pointer grows by temp step zero.
// - Plus-form step uses reverse carry propagation.
// - Compat mode off, minus form: pointer shrinks by temp step zero.
// - Minus-form step uses reverse borrow propagation.
// - Compat mode on: step comes from extended pointer zero, both forms.
// - No modulo wrap on the updated pointer, even when circular.
// - Circular pointer: zero-extended buffer start added to form the address.
// - Buffer start affects address only, never the stored pointer.
// - Single read fetches the word at pre-update address into destination.
// - Double read second address: even plus one, odd minus one.
// - First word to named register, second word to next pair register.
`timescale 1ns/10ps
module brg_addr_gen
  import brg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              op_valid,
  input  wire logic              op_minus,
  input  wire logic              op_double,
  input  wire logic [IDX_W-1:0]  op_ptr_idx,
  input  wire logic [IDX_W-1:0]  op_dst_idx,
  input  wire logic              legacy_compat_mode,
  input  wire logic [NUM_PTR-1:0] pointer_mode_status,
  input  wire logic [LOW_W-1:0]  circ_buffer_start,
  input  wire logic [LOW_W-1:0]  temp_step_zero,
  input  wire logic              ptr_load_en,
  input  wire logic [IDX_W-1:0]  ptr_load_idx,
  input  wire logic [PTR_W-1:0]  ptr_load_data,
  input  wire logic [DATA_W-1:0] mem_rd_data,
  output logic                   op_ready,
  output logic                   mem_rd_en,
  output logic [PTR_W-1:0]       mem_rd_addr,
  output logic                   dst_wr_en,
  output logic [IDX_W-1:0]       dst_wr_idx,
  output logic [DATA_W-1:0]      dst_wr_data,
  output logic [PTR_W-1:0]       ptr_updated
);

  // ==========================================================
  // Pointer file
  logic [PTR_W-1:0] extended_aux_pointer [NUM_PTR];

  // ==========================================================
  // Sequencer state
  brg_state_type    state;
  logic [PTR_W-1:0] first_addr;
  logic [IDX_W-1:0] dst_base;
  logic             rd_pending;
  logic             rd_second;
  logic             rd_issue_second;

  // ==========================================================
  // Local decoders
  // One slot compare shared by the step and load paths
  function automatic logic brg_slot_hit(input logic [IDX_W-1:0] idx, input int unsigned slot);
    return idx == IDX_W'(slot);
  endfunction : brg_slot_hit

  // Sixteen-bit fields widen with zeros, never with sign
  function automatic logic [PTR_W-1:0] brg_zero_ext(input logic [LOW_W-1:0] value);
    return {{HIGH_W{1'b0}}, value};
  endfunction : brg_zero_ext

  // ==========================================================
  // Combinational address and step selection
  logic             take_op;
  logic [PTR_W-1:0] cur_ptr;
  logic [PTR_W-1:0] access_addr;
  logic [PTR_W-1:0] step_value;
  logic [PTR_W-1:0] next_ptr;
  logic [NUM_PTR-1:0] step_hit;
  logic [NUM_PTR-1:0] load_hit;

  brg_step_if step_bus ();

  assign take_op = op_valid && op_ready;
  assign cur_ptr = extended_aux_pointer[op_ptr_idx];

  // Which slot the operand steps and which one software loads
  generate
    for (genvar h = 0; h < NUM_PTR; h++) begin : g_hit
      assign step_hit[h] = take_op && brg_slot_hit(op_ptr_idx, h);
      assign load_hit[h] = ptr_load_en && brg_slot_hit(ptr_load_idx, h);
    end
  endgenerate

  // Buffer start is folded into the address only
  always_comb begin
    if (pointer_mode_status[op_ptr_idx]) begin
      access_addr = cur_ptr + brg_zero_ext(circ_buffer_start);
    end else begin
      access_addr = cur_ptr;
    end
  end

  always_comb begin
    if (legacy_compat_mode) begin
      step_value = extended_aux_pointer[STEP_IDX];
    end else begin
      step_value = brg_zero_ext(temp_step_zero);
    end
  end

  assign step_bus.base  = cur_ptr;
  assign step_bus.step  = step_value;
  assign step_bus.minus = op_minus;

  brg_rev_adder u_rev_adder (
    .step_port (step_bus.unit)
  );

  // Raw step result; no circular wrap, no buffer start
  assign next_ptr = step_bus.result;

  // ==========================================================
  // Pointer file update
  // A stepped pointer wins over a software load to the same slot,
  // so an access never loses its post-modification.
  generate
    for (genvar g = 0; g < NUM_PTR; g++) begin : g_ptr
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          extended_aux_pointer[g] <= PTR_RST;
        end else if (step_hit[g]) begin
          extended_aux_pointer[g] <= next_ptr;
        end else if (load_hit[g]) begin
          extended_aux_pointer[g] <= ptr_load_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_updated <= PTR_RST;
    end else if (take_op) begin
      ptr_updated <= next_ptr;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= brg_idle;
      op_ready   <= 1'b1;
      first_addr <= PTR_RST;
      dst_base   <= IDX_RST;
    end else begin
      case (state)
        brg_idle: begin
          if (take_op) begin
            first_addr <= access_addr;
            dst_base   <= op_dst_idx;
            op_ready   <= 1'b0;
            state      <= op_double ? brg_second : brg_drain;
          end
        end
        brg_second: begin
          state <= brg_drain;
        end
        brg_drain: begin
          // Holds off the next operand until the last word has landed
          if (!rd_pending && !mem_rd_en) begin
            op_ready <= 1'b1;
            state    <= brg_idle;
          end
        end
        default: begin
          op_ready <= 1'b1;
          state    <= brg_idle;
        end
      endcase
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_rd_en   <= 1'b0;
      mem_rd_addr <= PTR_RST;
    end else if (take_op) begin
      mem_rd_en   <= 1'b1;
      mem_rd_addr <= access_addr;
    end else if (state == brg_second) begin
      mem_rd_en   <= 1'b1;
      mem_rd_addr <= brg_partner(first_addr);
    end else begin
      mem_rd_en   <= 1'b0;
    end
  end

  // Marks the cycle in which the partner word goes out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_issue_second <= 1'b0;
    end else begin
      rd_issue_second <= (state == brg_second);
    end
  end

  // Tracks which word of the pair returns next; order, not address, decides
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pending <= 1'b0;
      rd_second  <= 1'b0;
    end else begin
      rd_pending <= mem_rd_en;
      rd_second  <= mem_rd_en && rd_issue_second;
    end
  end

  // ==========================================================
  // Destination write port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dst_wr_en   <= 1'b0;
      dst_wr_idx  <= IDX_RST;
      dst_wr_data <= DATA_RST;
    end else if (rd_pending) begin
      dst_wr_en   <= 1'b1;
      dst_wr_data <= mem_rd_data;
      if (rd_second) begin
        dst_wr_idx <= dst_base + PAIR_NEXT;
      end else begin
        dst_wr_idx <= dst_base;
      end
    end else begin
      dst_wr_en   <= 1'b0;
    end
  end

endmodule : brg_addr_gen

// *** design/brg_pkg.sv ***
// Constants, types and helpers for the bit-reverse address generator
package brg_pkg;

  // ==========================================================
  // Widths
  localparam int PTR_W     = 23;
  localparam int LOW_W     = 16;
  localparam int HIGH_W    = 7;
  localparam int DATA_W    = 16;
  localparam int IDX_W     = 3;
  localparam int NUM_PTR   = 8;

  // ==========================================================
  // Field positions and reset values
  localparam int LOW_LSB   = 0;
  localparam int HIGH_LSB  = 16;
  localparam int PAIR_BIT  = 0;
  localparam int STEP_IDX  = 0;
  localparam logic [PTR_W-1:0]  PTR_RST   = 23'h00_0000;
  localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
  localparam logic [IDX_W-1:0]  IDX_RST   = 3'h0;
  localparam logic [IDX_W-1:0]  PAIR_NEXT = 3'h1;

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    brg_idle,
    brg_second,
    brg_drain
  } brg_state_type;

  // ==========================================================
  // Helpers
  function automatic logic [PTR_W-1:0] brg_reverse(input logic [PTR_W-1:0] value);
    logic [PTR_W-1:0] out;
    out = '0;
    for (int i = 0; i < PTR_W; i++) begin
      out[i] = value[PTR_W-1-i];
    end
    return out;
  endfunction : brg_reverse

  // Even word goes up by one, odd word goes down by one
  function automatic logic [PTR_W-1:0] brg_partner(input logic [PTR_W-1:0] first);
    logic [PTR_W-1:0] out;
    out = first[PAIR_BIT] ? first - 23'h00_0001 : first + 23'h00_0001;
    return out;
  endfunction : brg_partner

endpackage : brg_pkg

// *** design/brg_rev_adder.sv ***
// Reverse-carry adder and subtractor for pointer steps
`timescale 1ns/10ps
module brg_rev_adder
  import brg_pkg::*;
(
  brg_step_if.unit step_port
);

  // ==========================================================
  // Mirrored arithmetic
  logic [PTR_W-1:0] rev_base;
  logic [PTR_W-1:0] rev_step;
  logic [PTR_W-1:0] rev_result;

  assign rev_base = brg_reverse(step_port.base);
  assign rev_step = brg_reverse(step_port.step);

  // Carries and borrows run from the top bit downward
  always_comb begin
    if (step_port.minus) begin
      rev_result = rev_base - rev_step;
    end else begin
      rev_result = rev_base + rev_step;
    end
  end

  assign step_port.result = brg_reverse(rev_result);

endmodule : brg_rev_adder

// *** design/brg_step_if.sv ***
// Carrier between the sequencer and the reverse-carry step unit
`timescale 1ns/10ps
interface brg_step_if;
  import brg_pkg::*;

  logic [PTR_W-1:0] base;
  logic [PTR_W-1:0] step;
  logic             minus;
  logic [PTR_W-1:0] result;

  modport requester (output base, output step, output minus, input result);
  modport unit      (input base, input step, input minus, output result);

endinterface : brg_step_if

// *** verification/brg_addr_gen_sva.sv ***
// Port checker for the bit-reverse address generator
`timescale 1ns/10ps
module brg_addr_gen_sva
  import brg_pkg::*;
(
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               op_valid,
  input wire logic               op_ready,
  input wire logic               op_double,
  input wire logic               legacy_compat_mode,
  input wire logic [IDX_W-1:0]   op_ptr_idx,
  input wire logic [IDX_W-1:0]   op_dst_idx,
  input wire logic [NUM_PTR-1:0] pointer_mode_status,
  input wire logic [LOW_W-1:0]   circ_buffer_start,
  input wire logic [LOW_W-1:0]   temp_step_zero,
  input wire logic               mem_rd_en,
  input wire logic [PTR_W-1:0]   mem_rd_addr,
  input wire logic [DATA_W-1:0]  mem_rd_data,
  input wire logic               dst_wr_en,
  input wire logic [IDX_W-1:0]   dst_wr_idx,
  input wire logic [DATA_W-1:0]  dst_wr_data,
  input wire logic [PTR_W-1:0]   ptr_updated
);
  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire take = op_valid && op_ready;
  a_take_then_read: assert property (take |=> mem_rd_en && !op_ready)
    else $error("no read after take");
  a_ptr_held_idle: assert property (!take |=> $stable(ptr_updated))
    else $error("pointer moved without take");
  a_pair_address: assert property (mem_rd_en && $past(mem_rd_en) |-> mem_rd_addr ==
    ($past(mem_rd_addr[0]) ? $past(mem_rd_addr) - 23'h00_0001 : $past(mem_rd_addr) + 23'h00_0001))
    else $error("bad second address");
  a_word_to_dest: assert property (mem_rd_en |-> ##2 dst_wr_en && dst_wr_data == $past(mem_rd_data))
    else $error("read word lost");
  a_pair_dest_idx: assert property (take && op_double |-> ##3 dst_wr_idx == $past(op_dst_idx, 3)
    ##1 dst_wr_en && dst_wr_idx == $past(op_dst_idx, 4) + 3'h1)
    else $error("bad pair index");
  a_single_timing: assert property (take && !op_double |=> mem_rd_en ##1 !mem_rd_en && !op_ready ##1 !op_ready ##1 op_ready)
    else $error("single timing");
  a_double_timing: assert property (take && op_double |=> !op_ready [*4] ##1 op_ready)
    else $error("double timing");
  // Zero step exposes the raw pointer, so only the buffer start may separate them
  a_circ_addr_only: assert property (take && !legacy_compat_mode && temp_step_zero == 16'h0000 |=>
    mem_rd_addr == ptr_updated + ($past(pointer_mode_status[op_ptr_idx]) ? {7'h00, $past(circ_buffer_start)} : 23'h00_0000))
    else $error("bad circular address");
  c_single: cover property (take && !op_double);
  c_double: cover property (take && op_double);
  c_circ: cover property (take && pointer_mode_status[op_ptr_idx]);
endmodule : brg_addr_gen_sva

bind brg_addr_gen brg_addr_gen_sva u_sva (.clk, .sys_rst, .op_valid, .op_ready, .op_double, .legacy_compat_mode,
  .op_ptr_idx, .op_dst_idx, .pointer_mode_status, .circ_buffer_start, .temp_step_zero, .mem_rd_en, .mem_rd_addr,
  .mem_rd_data, .dst_wr_en, .dst_wr_idx, .dst_wr_data, .ptr_updated);

// *** verification/brg_reg_space_model.sv ***
// Register space answering the read path
`timescale 1ns/10ps
module brg_reg_space_model
  import brg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              mem_rd_en,
  input  wire logic [PTR_W-1:0]  mem_rd_addr,
  output logic      [DATA_W-1:0] mem_rd_data
);
  // ==========================================================
  // Word mixes its address; bus toggles between reads so stale data never matches
  initial mem_rd_data = DATA_RST;
  always @(posedge clk) begin
    mem_rd_data <= mem_rd_en ? mem_rd_addr[15:0] ^ 16'h5a3c : ~mem_rd_data;
  end
endmodule : brg_reg_space_model

// *** verification/tb_bit_reverse_addr_gen.sv ***
// Self-checking bench for the bit-reverse address generator
`timescale 1ns/10ps
module tb_bit_reverse_addr_gen;
  import brg_pkg::*;
  logic               clk, sys_rst, op_valid, op_minus, op_double, legacy_compat_mode, ptr_load_en;
  logic               op_ready, mem_rd_en, dst_wr_en;
  logic [IDX_W-1:0]   op_ptr_idx, op_dst_idx, ptr_load_idx, dst_wr_idx;
  logic [NUM_PTR-1:0] pointer_mode_status;
  logic [LOW_W-1:0]   circ_buffer_start, temp_step_zero;
  logic [PTR_W-1:0]   ptr_load_data, mem_rd_addr, ptr_updated, ptrs [NUM_PTR];
  logic [DATA_W-1:0]  mem_rd_data, dst_wr_data;
  int                 err_total, total_checks;

  brg_addr_gen dut (.clk, .sys_rst, .op_valid, .op_minus, .op_double, .op_ptr_idx, .op_dst_idx, .legacy_compat_mode,
    .pointer_mode_status, .circ_buffer_start, .temp_step_zero, .ptr_load_en, .ptr_load_idx, .ptr_load_data,
    .mem_rd_data, .op_ready, .mem_rd_en, .mem_rd_addr, .dst_wr_en, .dst_wr_idx, .dst_wr_data, .ptr_updated);
  brg_reg_space_model u_model (.clk, .mem_rd_en, .mem_rd_addr, .mem_rd_data);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [PTR_W-1:0] rev_bits(input logic [PTR_W-1:0] v);
    for (int i = 0; i < PTR_W; i++) rev_bits[i] = v[PTR_W-1-i];
  endfunction : rev_bits

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic load(input logic [IDX_W-1:0] idx, input logic [PTR_W-1:0] val);
    ptr_load_en = 1'b1;
    ptr_load_idx = idx;
    ptr_load_data = val;
    @(negedge clk);
    ptr_load_en = 1'b0;
    ptrs[idx] = val;
  endtask : load

  task automatic run_op(input logic mn, input logic dbl, input logic [IDX_W-1:0] pi, input logic [IDX_W-1:0] di);
    logic [PTR_W-1:0] a, b, st, np;
    st = legacy_compat_mode ? ptrs[0] : {7'h00, temp_step_zero};
    np = mn ? rev_bits(rev_bits(ptrs[pi]) - rev_bits(st)) : rev_bits(rev_bits(ptrs[pi]) + rev_bits(st));
    a = ptrs[pi] + (pointer_mode_status[pi] ? {7'h00, circ_buffer_start} : 23'h00_0000);
    b = a[0] ? a - 23'h00_0001 : a + 23'h00_0001;
    op_valid = 1'b1;
    op_minus = mn;
    op_double = dbl;
    op_ptr_idx = pi;
    op_dst_idx = di;
    @(negedge clk);
    op_valid = 1'b0;
    chk(mem_rd_addr, a);
    chk(ptr_updated, np);
    ptrs[pi] = np;
    @(negedge clk);
    if (dbl) chk(mem_rd_addr, b);
    @(negedge clk);
    chk({dst_wr_en, dst_wr_idx, dst_wr_data}, {1'b1, di, a[15:0] ^ 16'h5a3c});
    if (dbl) @(negedge clk);
    if (dbl) chk({dst_wr_en, dst_wr_idx, dst_wr_data}, {1'b1, di + 3'h1, b[15:0] ^ 16'h5a3c});
    chk(op_ready, 0);
    @(negedge clk);
    chk(op_ready, 1);
  endtask : run_op

  // ==========================================================
  // Scenarios
  task automatic t_plus();
    temp_step_zero = 16'h0100;
    load(3'h3, 23'h00_1200);
    run_op(1'b0, 1'b0, 3'h3, 3'h2);
    run_op(1'b0, 1'b1, 3'h3, 3'h2);
    chk(ptr_updated, 32'h0000_1280);
  endtask : t_plus

  task automatic t_minus();
    temp_step_zero = 16'h0008;
    run_op(1'b1, 1'b0, 3'h5, 3'h1);
    chk(ptr_updated, 32'h0000_000f);
  endtask : t_minus

  task automatic t_compat();
    legacy_compat_mode = 1'b1;
    load(3'h0, 23'h00_0040);
    @(negedge clk);
    load(3'h6, 23'h40_0001);
    run_op(1'b0, 1'b0, 3'h6, 3'h4);
    run_op(1'b1, 1'b1, 3'h6, 3'h7);
    legacy_compat_mode = 1'b0;
  endtask : t_compat

  task automatic t_circ();
    pointer_mode_status = 8'h04;
    circ_buffer_start = 16'hfff0;
    temp_step_zero = 16'h0000;
    load(3'h2, 23'h7f_ffff);
    run_op(1'b0, 1'b1, 3'h2, 3'h0);
    temp_step_zero = 16'h0a00;
    run_op(1'b1, 1'b0, 3'h2, 3'h3);
  endtask : t_circ

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    {sys_rst, op_valid, op_minus, op_double, legacy_compat_mode, ptr_load_en} = 6'h20;
    {op_ptr_idx, op_dst_idx, ptr_load_idx, pointer_mode_status} = '0;
    {circ_buffer_start, temp_step_zero, ptr_load_data} = '0;
    foreach (ptrs[i]) ptrs[i] = '0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk({op_ready, mem_rd_en, dst_wr_en, ptr_updated}, {3'h4, 23'h00_0000});
    t_plus();
    t_minus();
    t_compat();
    t_circ();
    tally_and_finish();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #20000;
    err_total++;
    tally_and_finish();
  end
endmodule : tb_bit_reverse_addr_gen
